// ===== hw/ist_front_end.sv
// Input scaling and tuner front end with AXI4-Lite register slave
`timescale 1ns/10ps
module ist_front_end
  import ist_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int MANT_W = IST_MANT_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [MANT_W-1:0] mantissa_a_in,
  input wire logic [IST_CODE_W-1:0] gain_range_code_a_in,
  input wire logic port_sample_qualifier_a_in,
  input wire logic [MANT_W-1:0] mantissa_b_in,
  input wire logic [IST_CODE_W-1:0] gain_range_code_b_in,
  input wire logic port_sample_qualifier_b_in,
  input wire logic level_indicator_in,
  input wire logic soft_sync_in,
  output logic signed [MANT_W-1:0] scaled_out,
  output logic [IST_SCALE_W-1:0] active_scale_out,
  output logic signed [IST_TRIG_W-1:0] tuned_i_out,
  output logic signed [IST_TRIG_W-1:0] tuned_q_out,
  output logic tuned_valid_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers and internal state
  logic [IST_SCALE_W-1:0] attenuated_scale_field;
  logic [IST_SCALE_W-1:0] unattenuated_scale_field;
  logic [IST_CODE_W-1:0] range_code_offset;
  logic range_code_invert;
  logic port_select;
  logic [IST_REG_W-1:0] tuning_holdoff_count;
  logic [IST_WORD_W-1:0] shadow_word;
  logic [IST_WORD_W-1:0] tuning_word;
  logic [IST_REG_W-1:0] holdoff_left;
  logic holdoff_busy;
  logic sync_req;

  logic lvl_ff1, lvl_ff2, lvl_ff3, lvl_active;
  logic ss_ff1, ss_ff2, ss_ff3, ss_level, ss_level_d;

  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wr_idx;

  logic signed [MANT_W-1:0] cap_mant;
  logic [IST_CODE_W-1:0] cap_code;
  logic cap_valid;
  logic scaled_valid;
  logic [IST_SCALE_W-1:0] sel_scale;
  logic [IST_CODE_W-1:0] base_shift;
  logic [IST_CODE_W-1:0] shift_amt;
  logic signed [IST_TRIG_W-1:0] osc_cos;
  logic signed [IST_TRIG_W-1:0] osc_sin;
  logic signed [MANT_W+IST_TRIG_W-1:0] prod_i;
  logic signed [MANT_W+IST_TRIG_W-1:0] prod_q;
  logic transfer;
  logic sync_event;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the write and read paths
  function automatic logic [7:0] ist_index(input logic [ADDR_W-1:0] addr);
    return addr[9:2];
  endfunction

  function automatic logic ist_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] i;
    i = ist_index(addr);
    return (addr[ADDR_W-1:10] == '0) && (addr[1:0] == 2'h0) &&
           ((i >= IST_IDX_HOLDOFF && i <= IST_IDX_WORD_B) ||
            (i >= IST_IDX_SCALE && i <= IST_IDX_ACT_B));
  endfunction

  // Merges the two low byte lanes into a 16-bit register
  function automatic logic [15:0] ist_merge(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = ist_index(aw_addr);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_awready <= 1'b1;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_wready <= 1'b1;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IST_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= ist_mapped(aw_addr) ? IST_RESP_OKAY : IST_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      attenuated_scale_field <= '0;
      unattenuated_scale_field <= '0;
      range_code_offset <= '0;
      range_code_invert <= 1'b0;
    end else if (do_write && wr_idx == IST_IDX_SCALE) begin
      if (w_strb[0]) begin
        attenuated_scale_field <= w_data[IST_ATT_LSB +: IST_SCALE_W];
      end
      if (w_strb[0] && w_strb[1]) begin
        unattenuated_scale_field <= w_data[IST_UNATT_LSB +: IST_SCALE_W];
      end
      if (w_strb[1]) begin
        range_code_offset <= w_data[IST_OFS_LSB +: IST_CODE_W];
        range_code_invert <= w_data[IST_INV_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_select <= 1'b0;
      sync_req <= 1'b0;
    end else begin
      sync_req <= 1'b0;
      if (do_write && wr_idx == IST_IDX_CTRL && w_strb[0]) begin
        port_select <= w_data[IST_CTRL_PORT_BIT];
        sync_req <= w_data[IST_CTRL_SYNC_BIT];
      end
    end
  end

  // Writes only touch the shadow; the active word is untouched here
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shadow_word <= IST_RST_WORD;
    end else if (do_write && wr_idx == IST_IDX_WORD_A) begin
      shadow_word[15:0] <= ist_merge(shadow_word[15:0], w_data, w_strb);
    end else if (do_write && wr_idx == IST_IDX_WORD_B) begin
      shadow_word[31:16] <= ist_merge(shadow_word[31:16], w_data, w_strb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lvl_ff1 <= 1'b0;
      lvl_ff2 <= 1'b0;
      lvl_ff3 <= 1'b0;
      lvl_active <= 1'b0;
    end else begin
      lvl_ff1 <= level_indicator_in;
      lvl_ff2 <= lvl_ff1;
      lvl_ff3 <= lvl_ff2;
      if (lvl_ff2 == lvl_ff3) begin
        lvl_active <= lvl_ff3;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ss_ff1 <= 1'b0;
      ss_ff2 <= 1'b0;
      ss_ff3 <= 1'b0;
      ss_level <= 1'b0;
      ss_level_d <= 1'b0;
    end else begin
      ss_ff1 <= soft_sync_in;
      ss_ff2 <= ss_ff1;
      ss_ff3 <= ss_ff2;
      ss_level_d <= ss_level;
      if (ss_ff2 == ss_ff3) begin
        ss_level <= ss_ff3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold-off counter and shadow transfer
  assign sync_event = sync_req || (ss_level && !ss_level_d);
  assign transfer = sync_event || (holdoff_busy && holdoff_left == '0);

  // Writing the count arms it; a soft sync overrides a pending hold-off
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tuning_holdoff_count <= IST_RST_REG;
      holdoff_left <= '0;
      holdoff_busy <= 1'b0;
    end else if (do_write && wr_idx == IST_IDX_HOLDOFF) begin
      tuning_holdoff_count <= ist_merge(tuning_holdoff_count, w_data, w_strb);
      holdoff_left <= ist_merge(tuning_holdoff_count, w_data, w_strb);
      holdoff_busy <= 1'b1;
    end else if (transfer) begin
      holdoff_busy <= 1'b0;
    end else if (holdoff_busy) begin
      holdoff_left <= holdoff_left - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tuning_word <= IST_RST_WORD;
    end else if (transfer) begin
      tuning_word <= shadow_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= IST_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ist_mapped(s_axi_araddr) ? IST_RESP_OKAY : IST_RESP_SLVERR;
      s_axi_rdata <= '0;
      if (ist_mapped(s_axi_araddr)) begin
        unique case (ist_index(s_axi_araddr))
          IST_IDX_HOLDOFF: s_axi_rdata[15:0] <= tuning_holdoff_count;
          IST_IDX_WORD_A: s_axi_rdata[15:0] <= shadow_word[15:0];
          IST_IDX_WORD_B: s_axi_rdata[15:0] <= shadow_word[31:16];
          IST_IDX_SCALE: begin
            s_axi_rdata[IST_ATT_LSB +: IST_SCALE_W] <= attenuated_scale_field;
            s_axi_rdata[IST_UNATT_LSB +: IST_SCALE_W] <= unattenuated_scale_field;
            s_axi_rdata[IST_OFS_LSB +: IST_CODE_W] <= range_code_offset;
            s_axi_rdata[IST_INV_BIT] <= range_code_invert;
          end
          IST_IDX_CTRL: s_axi_rdata[IST_CTRL_PORT_BIT] <= port_select;
          IST_IDX_STATUS: begin
            s_axi_rdata[IST_STAT_BUSY_BIT] <= holdoff_busy;
            s_axi_rdata[IST_STAT_LEVEL_BIT] <= lvl_active;
          end
          IST_IDX_ACT_A: s_axi_rdata[15:0] <= tuning_word[15:0];
          IST_IDX_ACT_B: s_axi_rdata[15:0] <= tuning_word[31:16];
          default: s_axi_rdata <= '0;
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path: capture, scale, tune
  // Narrow converters are expected MSB-justified with low bits tied zero
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cap_mant <= '0;
      cap_code <= '0;
      cap_valid <= 1'b0;
    end else begin
      cap_mant <= port_select ? mantissa_b_in : mantissa_a_in;
      cap_code <= port_select ? gain_range_code_b_in : gain_range_code_a_in;
      cap_valid <= port_select ? port_sample_qualifier_b_in : port_sample_qualifier_a_in;
    end
  end

  // Only the low three scale bits reach the input shifter; all five go downstream
  always_comb begin
    sel_scale = lvl_active ? attenuated_scale_field : unattenuated_scale_field;
    base_shift = range_code_invert ? 3'(3'd7 - cap_code) : cap_code;
    shift_amt = 3'(base_shift + range_code_offset + sel_scale[2:0]);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scaled_out <= '0;
      scaled_valid <= 1'b0;
      active_scale_out <= '0;
    end else begin
      scaled_out <= cap_mant >>> shift_amt;
      scaled_valid <= cap_valid;
      active_scale_out <= sel_scale;
    end
  end

  ist_tuning_osc #(
    .WORD_W(IST_WORD_W)
  ) u_osc (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .tuning_word_in(tuning_word),
    .cos_out(osc_cos),
    .sin_out(osc_sin)
  );

  // Real input times exp(-j phase): I = x cos, Q = -x sin
  always_comb begin
    prod_i = scaled_out * osc_cos;
    prod_q = scaled_out * osc_sin;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tuned_i_out <= '0;
      tuned_q_out <= '0;
      tuned_valid_out <= 1'b0;
    end else begin
      tuned_i_out <= prod_i[MANT_W+IST_TRIG_W-2 -: IST_TRIG_W];
      tuned_q_out <= 16'(-prod_q[MANT_W+IST_TRIG_W-2 -: IST_TRIG_W]);
      tuned_valid_out <= scaled_valid;
    end
  end
endmodule

// ===== hw/ist_pkg.sv
// Constants for the input scaling and tuner front end
package ist_pkg;
  localparam int IST_MANT_W = 14;
  localparam int IST_CODE_W = 3;
  localparam int IST_SCALE_W = 5;
  localparam int IST_WORD_W = 32;
  localparam int IST_TRIG_W = 16;
  localparam int IST_REG_W = 16;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IST_IDX_HOLDOFF = 8'h84;
  localparam logic [7:0] IST_IDX_WORD_A = 8'h85;
  localparam logic [7:0] IST_IDX_WORD_B = 8'h86;
  localparam logic [7:0] IST_IDX_SCALE = 8'h92;
  localparam logic [7:0] IST_IDX_CTRL = 8'h93;
  localparam logic [7:0] IST_IDX_STATUS = 8'h94;
  localparam logic [7:0] IST_IDX_ACT_A = 8'h95;
  localparam logic [7:0] IST_IDX_ACT_B = 8'h96;
  // Field positions in the scale register
  localparam int IST_ATT_LSB = 0;
  localparam int IST_UNATT_LSB = 5;
  localparam int IST_OFS_LSB = 10;
  localparam int IST_INV_BIT = 13;
  // Control and status bits
  localparam int IST_CTRL_SYNC_BIT = 0;
  localparam int IST_CTRL_PORT_BIT = 1;
  localparam int IST_STAT_BUSY_BIT = 0;
  localparam int IST_STAT_LEVEL_BIT = 1;
  // Reset values
  localparam logic [15:0] IST_RST_REG = 16'h0000;
  localparam logic [31:0] IST_RST_WORD = 32'h0000_0000;
  // Bus answers
  localparam logic [1:0] IST_RESP_OKAY = 2'h0;
  localparam logic [1:0] IST_RESP_SLVERR = 2'h2;
endpackage

// ===== hw/ist_tuning_osc.sv
// Complex tuning oscillator: phase accumulator and quarter-wave sine lookup
`timescale 1ns/10ps
module ist_tuning_osc
  import ist_pkg::*;
#(
  parameter int WORD_W = IST_WORD_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [WORD_W-1:0] tuning_word_in,
  output logic signed [IST_TRIG_W-1:0] cos_out,
  output logic signed [IST_TRIG_W-1:0] sin_out
);
  logic [WORD_W-1:0] phase;

  function automatic logic [15:0] ist_quarter(input logic [3:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    unique case (idx)
      4'h0: v = 16'h0648;
      4'h1: v = 16'h12C8;
      4'h2: v = 16'h1F1A;
      4'h3: v = 16'h2B1F;
      4'h4: v = 16'h36BA;
      4'h5: v = 16'h41CE;
      4'h6: v = 16'h4C40;
      4'h7: v = 16'h55F5;
      4'h8: v = 16'h5ED7;
      4'h9: v = 16'h66CF;
      4'hA: v = 16'h6DC9;
      4'hB: v = 16'h73B5;
      4'hC: v = 16'h7884;
      4'hD: v = 16'h7C29;
      4'hE: v = 16'h7E9C;
      4'hF: v = 16'h7FD8;
    endcase
    return v;
  endfunction

  // Sine of a 6-bit phase; cosine is the same lookup a quarter turn ahead
  function automatic logic [15:0] ist_sine(input logic [5:0] p);
    logic [15:0] m;
    m = p[4] ? ist_quarter(~p[3:0]) : ist_quarter(p[3:0]);
    return p[5] ? 16'(-m) : m;
  endfunction

  // Phase wraps modulo two to the 32, covering minus to plus half the clock
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase <= '0;
    end else begin
      phase <= phase + tuning_word_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cos_out <= '0;
      sin_out <= '0;
    end else begin
      sin_out <= ist_sine(phase[WORD_W-1 -: 6]);
      cos_out <= ist_sine(6'(phase[WORD_W-1 -: 6] + 6'h10));
    end
  end
endmodule

// ===== tb/ist_adc_model.sv
// Behavioural converter driving one input port of the front end
`timescale 1ns/10ps
module ist_adc_model #(
  parameter int BITS = 14
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic signed [BITS-1:0] sample_in,
  input wire logic [2:0] code_in,
  input wire logic valid_in,
  output logic [13:0] mantissa_out,
  output logic [2:0] code_out,
  output logic qualifier_out
);
  // Launched after the edge so the front end samples a settled word
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mantissa_out <= 14'h0000;
      code_out <= 3'h0;
      qualifier_out <= 1'h0;
    end else begin
      qualifier_out <= valid_in;
      code_out <= code_in;
      if (valid_in) begin
        mantissa_out <= 14'(sample_in) << (14 - BITS);
      end else begin
        // Stale word is not held: a lingering value must not pass for data
        mantissa_out <= ~mantissa_out;
      end
    end
  end
endmodule

// ===== tb/ist_front_end_properties.sv
// Bus and pipeline checks bound to the front end ports
`timescale 1ns/10ps
module ist_front_end_properties
  import ist_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port_sample_qualifier_a_in,
  input wire logic port_sample_qualifier_b_in,
  input wire logic tuned_valid_out
);
  // Byte addresses of the mapped words; anything else is refused
  wire ar_map = s_axi_araddr inside {12'h210, 12'h214, 12'h218, 12'h248, 12'h24C, 12'h250, 12'h254, 12'h258};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write slot not reopened");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && !ar_map |=>
    s_axi_rresp == IST_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_valid_align: assert property ($past(port_sample_qualifier_a_in, 3) == $past(port_sample_qualifier_b_in, 3) |->
    tuned_valid_out == $past(port_sample_qualifier_a_in, 3))
    else $error("tuned valid misaligned");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == IST_RESP_SLVERR);
  cover property ($rose(tuned_valid_out));
endmodule
bind ist_front_end ist_front_end_properties #(.ADDR_W(ADDR_W)) i_chk (.clk_sys_in, .rst_b_in, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .port_sample_qualifier_a_in, .port_sample_qualifier_b_in, .tuned_valid_out);

// ===== tb/ist_front_end_tb_top.sv
// Register and data path tests of the input scaling and tuner front end
`timescale 1ns/10ps
module ist_front_end_tb_top;
  import ist_pkg::*;
  logic clk_sys_in = 1'h0, rst_b_in = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tuned_valid_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [13:0] mant_a, mant_b;
  logic [2:0] code_a, code_b, rc_a = 3'h0;
  logic qual_a, qual_b, qual_in = 1'h0, level_indicator_in = 1'h0, soft_sync_in = 1'h0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic [2:0] axi_prot = 3'h0;
  logic signed [11:0] smp_a = 12'h5A3;
  logic signed [13:0] smp_b = 14'h2345, scaled_out;
  logic [4:0] active_scale_out;
  logic signed [15:0] tuned_i_out, tuned_q_out, i_hold, q_hold;
  logic [7:0] map_idx [8] = '{IST_IDX_HOLDOFF, IST_IDX_WORD_A, IST_IDX_WORD_B, IST_IDX_SCALE, IST_IDX_CTRL,
    IST_IDX_STATUS, IST_IDX_ACT_A, IST_IDX_ACT_B};
  int fails = 0, total_checks = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  ist_front_end i_dut (.clk_sys_in, .rst_b_in, .s_axi_awaddr, .s_axi_awprot(axi_prot), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(axi_prot), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mantissa_a_in(mant_a), .gain_range_code_a_in(code_a), .port_sample_qualifier_a_in(qual_a),
    .mantissa_b_in(mant_b), .gain_range_code_b_in(code_b), .port_sample_qualifier_b_in(qual_b),
    .level_indicator_in, .soft_sync_in, .scaled_out, .active_scale_out, .tuned_i_out, .tuned_q_out, .tuned_valid_out);
  // Port A: 12-bit gain-ranging converter; port B: 14-bit fixed-point with range code held low
  ist_adc_model #(.BITS(12)) i_adc_a (.clk_sys_in, .rst_b_in, .sample_in(smp_a), .code_in(rc_a), .valid_in(qual_in),
    .mantissa_out(mant_a), .code_out(code_a), .qualifier_out(qual_a));
  ist_adc_model #(.BITS(14)) i_adc_b (.clk_sys_in, .rst_b_in, .sample_in(smp_b), .code_in(3'h0), .valid_in(qual_in),
    .mantissa_out(mant_b), .code_out(code_b), .qualifier_out(qual_b));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic axi_wr(input logic [7:0] idx, input logic [15:0] val, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {16'h0000, val};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys_in);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    if (s_axi_bvalid !== 1'h1) begin
      fails++;
      finish_test();
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys_in);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    if (s_axi_rvalid !== 1'h1) begin
      fails++;
      finish_test();
    end
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    axi_rd(idx, rd, rsp);
    check("register", rd, exp);
  endtask
  // Shift amount worked out independently; 3-bit sum wraps modulo eight
  function automatic logic [2:0] exp_shift(input logic inv, input logic [2:0] ofs, input logic [4:0] sc,
    input logic [2:0] rc);
    exp_shift = (inv ? 3'h7 - rc : rc) + ofs + sc[2:0];
  endfunction
  task automatic scale_case(input logic inv, input logic [2:0] ofs, input logic [4:0] att, input logic [4:0] un,
    input logic lvl);
    int c;
    logic signed [13:0] m;
    axi_wr(IST_IDX_SCALE, {2'h0, inv, ofs, un, att}, rsp);
    @(posedge clk_sys_in);
    level_indicator_in <= lvl;
    for (c = 0; c < 8; c++) begin
      @(posedge clk_sys_in);
      rc_a <= c[2:0];
      settle(10);
      m = {smp_a, 2'h0};
      check("scaled", 32'(scaled_out), 32'(m >>> exp_shift(inv, ofs, lvl ? att : un, c[2:0])));
      check("scale_sel", 32'(active_scale_out), 32'(lvl ? att : un));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge clk_sys_in);
    fails++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'h1;
    foreach (map_idx[i]) rd_chk(map_idx[i], 32'h0000_0000);
    axi_rd(8'h90, rd, rsp);
    check("unmapped_rd", 32'(rsp), 32'(IST_RESP_SLVERR));
    axi_wr(8'h90, 16'hFFFF, rsp);
    check("unmapped_wr", 32'(rsp), 32'(IST_RESP_SLVERR));
    @(posedge clk_sys_in);
    qual_in <= 1'h1;
    settle(8);
    // Zero tuning word: oscillator stands still, so both products hold steady
    i_hold = tuned_i_out;
    q_hold = tuned_q_out;
    settle(4);
    check("tuned_i", 32'(tuned_i_out), 32'(i_hold));
    check("tuned_q", 32'(tuned_q_out), 32'(q_hold));
    check("tuned_i_sign", 32'(tuned_i_out > 0), 32'h0000_0001);
    check("tuned_valid", 32'(tuned_valid_out), 32'h0000_0001);
    qual_in <= 1'h0;
    settle(8);
    check("tuned_valid", 32'(tuned_valid_out), 32'h0000_0000);
    qual_in <= 1'h1;
    scale_case(1'h0, 3'h0, 5'h00, 5'h00, 1'h0);
    scale_case(1'h1, 3'h0, 5'h00, 5'h00, 1'h0);
    scale_case(1'h1, 3'h6, 5'h00, 5'h00, 1'h0);
    smp_a <= 12'hA5C;
    scale_case(1'h0, 3'h0, 5'h09, 5'h02, 1'h1);
    scale_case(1'h1, 3'h3, 5'h09, 5'h02, 1'h0);
    // Low lane only: unattenuated field, offset and invert keep their values
    s_axi_wstrb <= 4'h1;
    axi_wr(IST_IDX_SCALE, 16'hFFFF, rsp);
    s_axi_wstrb <= 4'h3;
    rd_chk(IST_IDX_SCALE, 32'h0000_2C5F);
    axi_wr(IST_IDX_SCALE, 16'h0000, rsp);
    axi_wr(IST_IDX_CTRL, 16'h0002, rsp);
    settle(8);
    check("port_b", 32'(scaled_out), 32'(smp_b));
    axi_wr(IST_IDX_CTRL, 16'h0000, rsp);
    axi_wr(IST_IDX_WORD_A, 16'h1234, rsp);
    axi_wr(IST_IDX_WORD_B, 16'h0040, rsp);
    rd_chk(IST_IDX_ACT_A, 32'h0000_0000);
    rd_chk(IST_IDX_WORD_B, 32'h0000_0040);
    axi_wr(IST_IDX_HOLDOFF, 16'h0014, rsp);
    rd_chk(IST_IDX_ACT_A, 32'h0000_0000);
    axi_rd(IST_IDX_STATUS, rd, rsp);
    check("busy", rd & 32'h0000_0001, 32'h0000_0001);
    settle(30);
    rd_chk(IST_IDX_ACT_A, 32'h0000_1234);
    rd_chk(IST_IDX_ACT_B, 32'h0000_0040);
    axi_wr(IST_IDX_WORD_A, 16'hBEEF, rsp);
    soft_sync_in <= 1'h1;
    repeat (6) @(posedge clk_sys_in);
    soft_sync_in <= 1'h0;
    settle(6);
    rd_chk(IST_IDX_ACT_A, 32'h0000_BEEF);
    axi_wr(IST_IDX_WORD_B, 16'h0101, rsp);
    axi_wr(IST_IDX_CTRL, 16'h0001, rsp);
    rd_chk(IST_IDX_ACT_B, 32'h0000_0101);
    finish_test();
  end
endmodule
